/* File: pkg/fpm_params.svh */
/*
 fault protection manager constants: register offsets, field positions,
 reset values and timing counts. assumes a 10 MHz clock.
*/
`ifndef FPM_PARAMS_SVH
`define FPM_PARAMS_SVH
`define FPM_A_CTRL    8'h00
`define FPM_A_OVCFG   8'h04
`define FPM_A_RESP    8'h08
`define FPM_A_OCLIM   8'h0C
`define FPM_A_OCWARN  8'h10
`define FPM_A_OT      8'h14
`define FPM_A_WARN    8'h18
`define FPM_A_PHLIM   8'h1C
`define FPM_A_SETPT   8'h20
`define FPM_A_STATUS  8'h24
`define FPM_C_GFE     0
`define FPM_C_FIXALL  1
`define FPM_C_OVREL   2
`define FPM_C_UVCMP   3
`define FPM_C_STACT   4
`define FPM_C_CLR     6
`define FPM_R_CTRL    32'h0000_0001
`define FPM_R_OVCFG   32'h0000_0000
`define FPM_R_RESP    32'hC0F8_8080
`define FPM_R_OCLIM   32'h00FF_01FF
`define FPM_R_OCWARN  32'h00FF_01FF
`define FPM_R_OT      32'h0000_7D64
`define FPM_R_WARN    32'h0000_0008
`define FPM_R_PHLIM   32'h0000_00FE
`define FPM_R_SETPT   32'h0384_0384
`define FPM_OV_REL_MV 16'd248
`define FPM_UV_FIX_MV 16'd248
`define FPM_REL_STEP  16'd50
`define FPM_CLK_NS    100
`define FPM_STEP_NS   5000
`define FPM_STEP_CYC  (`FPM_STEP_NS / `FPM_CLK_NS)
`define FPM_HIC_US    1000
`define FPM_HIC_CYC   ((`FPM_HIC_US * 1000) / `FPM_CLK_NS)
`define FPM_HIC_MAX   3'd6
`endif

/* File: pkg/fpm_pkg.sv */
/*
 fault protection manager types.
 assumes fpm_params.svh for numeric constants.
*/
package fpm_pkg;
   typedef struct packed {
      logic        en;
      logic        ss_done;
      logic        dynamic_voltage_change_up;
      logic        dynamic_voltage_change_down;
      logic        stage_rail;
      logic [15:0] vout_mv;
      logic [9:0]  iout_a;
      logic [9:0]  isum_a;
   } fpm_loop_in_t;
   typedef struct packed {
      logic run;
      logic low_side_on;
      logic hiccup;
   } fpm_loop_out_t;
   typedef enum logic [2:0] {FLT_OV, FLT_UV, FLT_OC, FLT_OT, FLT_ST} fpm_flt_t;
   typedef struct packed {
      logic              aw_f, w_f, b_v, r_v, b_err, r_err;
      logic [7:0]        aw_a;
      logic [31:0]       w_d;
      logic [3:0]        w_s;
      logic [31:0]       r_d;
      logic [8:0][31:0]  regs;
      logic [1:0][4:0]   sts;
      logic [1:0]        en_prev, latch, clamp, ot_hold, hic, wpin;
      logic [1:0][10:0]  oc_cnt;
      logic [1:0][23:0]  hic_cnt;
      logic [1:0][2:0]   retries;
      logic              hot;
      logic [1:0][21:0]  wrel_cnt;
   } fpm_state_t;
endpackage

/* File: rtl/fpm_vr_fault_protection_manager.sv */
/*
 fault protection manager for a dual-loop buck controller with an
 AXI4-Lite register slave. assumes sensed values arrive synchronous to
 aclk in mV, A and degrees C.
*/
`timescale 1ns/10ps
`include "fpm_params.svh"
module fpm_vr_fault_protection_manager #(
   parameter int unsigned HIC_CYC = `FPM_HIC_CYC
) (
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // axi4-lite write
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // loops
   input  fpm_pkg::fpm_loop_in_t      loop_in [2],
   output fpm_pkg::fpm_loop_out_t     loop_out [2],
   // phases
   input  wire logic [3:0][7:0]       phase_current,
   input  wire logic [3:0]            pwm_in,
   output logic [3:0]                 pwm_out,
   // temperature and warnings
   input  wire logic [1:0][8:0]       temp_sense_input,
   output logic                       hot_warning_n,
   output logic [1:0]                 oc_warn_n,
   output logic                       smb_alert_n
);
   import fpm_pkg::*;

   fpm_state_t s_q, s_d;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[8*b +: 8] = n[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [3:0] reg_idx(input logic [7:0] a);
      return a[5:2];
   endfunction

   // relative offset: 50 mV per code step, code 0 is 50 mV
   function automatic logic [15:0] rel_mv(input logic [2:0] c);
      return 16'(({13'd0, c} + 16'd1) * `FPM_REL_STEP);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl, ovcfg, resp, oclim, ocwarn, otr, warnr, phlim, setpt;
   logic [8:0]  tmax;
   logic [1:0]  off_own, warn_flag;
   logic [1:0]  run_v;

   always_comb begin
      ctrl   = s_q.regs[0];
      ovcfg  = s_q.regs[1];
      resp   = s_q.regs[2];
      oclim  = s_q.regs[3];
      ocwarn = s_q.regs[4];
      otr    = s_q.regs[5];
      warnr  = s_q.regs[6];
      phlim  = s_q.regs[7];
      setpt  = s_q.regs[8];
      tmax = (temp_sense_input[0] > temp_sense_input[1]) ?
             temp_sense_input[0] : temp_sense_input[1];
      for (int l = 0; l < 2; l++) begin
         off_own[l] = s_q.latch[l] | s_q.hic[l] | s_q.ot_hold[l] |
                      (loop_in[l].stage_rail &
                       ctrl[`FPM_C_STACT +: 2] == 2'd1);
      end
      for (int l = 0; l < 2; l++) begin
         run_v[l] = loop_in[l].en &
                    !(ctrl[`FPM_C_GFE] ? |off_own : off_own[l]);
      end
      warn_flag[0] = {1'b0, loop_in[0].isum_a} > {ocwarn[8:0], 1'b0};
      warn_flag[1] = {1'b0, loop_in[1].isum_a} > {ocwarn[24:16], 1'b0};
   end

   ////////////////////////////////////////////////////////////////////////
   logic [15:0] thr, vo, sp;
   logic        fixed_on, ov, uv, oc_over, trip;
   logic [10:0] oc_dly;
   logic [9:0]  lim2;
   logic [1:0]  sel;
   logic        src;
   logic [21:0] rel;

   always_comb begin
      s_d = s_q;
      thr = 16'h0000;
      vo = 16'h0000;
      sp = 16'h0000;
      fixed_on = 1'b0;
      ov = 1'b0;
      uv = 1'b0;
      oc_over = 1'b0;
      trip = 1'b0;
      lim2 = 10'h000;
      sel = 2'h0;
      src = 1'b0;
      oc_dly = 11'(otr[20:16] * `FPM_STEP_CYC);
      rel = 22'(warnr[31:16] * `FPM_STEP_CYC);
      // clear command stands for the one cycle after its write
      s_d.regs[0][`FPM_C_CLR] = 1'b0;
      // write channel, address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_f = 1'b1;
         s_d.aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_f = 1'b1;
         s_d.w_d = s_axi_wdata;
         s_d.w_s = s_axi_wstrb;
      end
      if (s_q.aw_f && s_q.w_f) begin
         s_d.aw_f = 1'b0;
         s_d.w_f = 1'b0;
         s_d.b_v = 1'b1;
         s_d.b_err = 1'b0;
         if (s_q.aw_a[1:0] != 2'b00 || reg_idx(s_q.aw_a) > 4'd9) begin
            s_d.b_err = 1'b1;
         end else if (reg_idx(s_q.aw_a) < 4'd9) begin
            s_d.regs[reg_idx(s_q.aw_a)] =
               merge(s_q.regs[reg_idx(s_q.aw_a)], s_q.w_d, s_q.w_s);
         end
      end
      if (s_q.b_v && s_axi_bready) begin
         s_d.b_v = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_d.r_v = 1'b1;
         s_d.r_err = 1'b0;
         s_d.r_d = 32'h0000_0000;
         if (s_axi_araddr[1:0] != 2'b00 || reg_idx(s_axi_araddr) > 4'd9) begin
            s_d.r_err = 1'b1;
         end else if (reg_idx(s_axi_araddr) == 4'd9) begin
            s_d.r_d = {15'd0, s_q.hot, s_q.hic, s_q.latch, s_q.clamp,
                       s_q.sts[1], s_q.sts[0]};
         end else begin
            s_d.r_d = s_q.regs[reg_idx(s_axi_araddr)];
         end
      end
      if (s_q.r_v && s_axi_rready) begin
         s_d.r_v = 1'b0;
      end

      // per-loop protection
      for (int l = 0; l < 2; l++) begin
         vo = loop_in[l].vout_mv;
         sp = setpt[16*l +: 16];
         s_d.en_prev[l] = loop_in[l].en;
         if (ctrl[`FPM_C_CLR] || (loop_in[l].en && !s_q.en_prev[l])) begin
            s_d.sts[l] = 5'b00000;
         end
         if (loop_in[l].en && !s_q.en_prev[l]) begin
            s_d.latch[l] = 1'b0;
            s_d.clamp[l] = 1'b0;
            s_d.retries[l] = 3'd0;
         end
         case (ovcfg[1:0])
            2'd0:    thr = 16'd2500;
            2'd1:    thr = 16'd1200;
            2'd2:    thr = 16'd1275;
            default: thr = 16'd1350;
         endcase
         fixed_on = !loop_in[l].en || !loop_in[l].ss_done ||
                    ctrl[`FPM_C_FIXALL];
         if (!fixed_on) begin
            thr = sp + rel_mv(ovcfg[4:2]);
         end
         ov = (vo > thr) && !loop_in[l].dynamic_voltage_change_down;
         if (ov) begin
            s_d.sts[l][FLT_OV] = 1'b1;
            if (resp[7]) begin
               s_d.clamp[l] = 1'b1;
               s_d.latch[l] = 1'b1;
            end
         end else if (s_q.clamp[l] && ctrl[`FPM_C_OVREL] &&
                      vo < `FPM_OV_REL_MV) begin
            s_d.clamp[l] = 1'b0;
         end
         uv = ctrl[`FPM_C_UVCMP] ?
              ({1'b0, vo} + {1'b0, rel_mv(ovcfg[7:5])} < {1'b0, sp}) :
              (vo < `FPM_UV_FIX_MV);
         if (uv && loop_in[l].ss_done && resp[15:8] != 8'h00) begin
            s_d.sts[l][FLT_UV] = 1'b1;
            s_d.latch[l] = 1'b1;
         end
         lim2 = (l == 0) ? {oclim[8:0], 1'b0} : {1'b0, oclim[23:16], 1'b0};
         oc_over = loop_in[l].iout_a > lim2 && loop_in[l].ss_done &&
                   !loop_in[l].dynamic_voltage_change_up && run_v[l];
         if (!oc_over) begin
            s_d.oc_cnt[l] = 11'd0;
         end else if (s_q.oc_cnt[l] >= oc_dly) begin
            trip = 1'b1;
            s_d.oc_cnt[l] = 11'd0;
         end else begin
            s_d.oc_cnt[l] = s_q.oc_cnt[l] + 11'd1;
         end
         if (trip) begin
            s_d.sts[l][FLT_OC] = 1'b1;
            case (resp[23:16])
               8'hC0: s_d.latch[l] = 1'b1;
               8'hF8: s_d.hic[l] = 1'b1;
               8'hF0: begin
                  if (s_q.retries[l] == `FPM_HIC_MAX) begin
                     s_d.latch[l] = 1'b1;
                  end else begin
                     s_d.hic[l] = 1'b1;
                     s_d.retries[l] = s_q.retries[l] + 3'd1;
                  end
               end
               default: s_d.latch[l] = 1'b1;
            endcase
         end
         trip = 1'b0;
         if (s_q.hic[l]) begin
            if (s_q.hic_cnt[l] >= 24'(HIC_CYC - 1)) begin
               s_d.hic[l] = 1'b0;
               s_d.hic_cnt[l] = 24'd0;
            end else begin
               s_d.hic_cnt[l] = s_q.hic_cnt[l] + 24'd1;
            end
         end
         if (tmax > {1'b0, otr[15:8]}) begin
            s_d.sts[l][FLT_OT] = 1'b1;
            case (resp[31:24])
               8'h80:   s_d.latch[l] = 1'b1;
               8'hC0:   s_d.ot_hold[l] = 1'b1;
               default: s_d.ot_hold[l] = s_q.ot_hold[l];
            endcase
         end else if (tmax < {1'b0, otr[15:8]}) begin
            s_d.ot_hold[l] = 1'b0;
         end
         if (loop_in[l].stage_rail) begin
            s_d.sts[l][FLT_ST] = 1'b1;
            if (ctrl[`FPM_C_STACT +: 2] == 2'd0) begin
               s_d.latch[l] = 1'b1;
            end
         end
      end

      // hot warning with 95 percent release
      if (tmax > {1'b0, otr[7:0]}) begin
         s_d.hot = 1'b1;
      end else if (15'(tmax * 20) < 15'(otr[7:0] * 19)) begin
         s_d.hot = 1'b0;
      end

      // warning pins
      for (int p = 0; p < 2; p++) begin
         sel = warnr[2*p +: 2];
         case (sel)
            2'd0:    src = warn_flag[0];
            2'd1:    src = warn_flag[1];
            2'd2:    src = |warn_flag;
            default: src = 1'b0;
         endcase
         if (src) begin
            s_d.wpin[p] = 1'b1;
            s_d.wrel_cnt[p] = 22'd0;
         end else if (s_q.wpin[p]) begin
            if (s_q.wrel_cnt[p] >= rel) begin
               s_d.wpin[p] = 1'b0;
               s_d.wrel_cnt[p] = 22'd0;
            end else begin
               s_d.wrel_cnt[p] = s_q.wrel_cnt[p] + 22'd1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.regs[0] <= `FPM_R_CTRL;
         s_q.regs[1] <= `FPM_R_OVCFG;
         s_q.regs[2] <= `FPM_R_RESP;
         s_q.regs[3] <= `FPM_R_OCLIM;
         s_q.regs[4] <= `FPM_R_OCWARN;
         s_q.regs[5] <= `FPM_R_OT;
         s_q.regs[6] <= `FPM_R_WARN;
         s_q.regs[7] <= `FPM_R_PHLIM;
         s_q.regs[8] <= `FPM_R_SETPT;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_axi_awready = !s_q.aw_f && !s_q.b_v;
      s_axi_wready  = !s_q.w_f && !s_q.b_v;
      s_axi_bvalid  = s_q.b_v;
      s_axi_bresp   = s_q.b_err ? 2'b10 : 2'b00;
      s_axi_arready = !s_q.r_v;
      s_axi_rvalid  = s_q.r_v;
      s_axi_rdata   = s_q.r_d;
      s_axi_rresp   = s_q.r_err ? 2'b10 : 2'b00;
      for (int l = 0; l < 2; l++) begin
         loop_out[l].run = run_v[l];
         loop_out[l].low_side_on = s_q.clamp[l];
         loop_out[l].hiccup = s_q.hic[l];
      end
      for (int i = 0; i < 4; i++) begin
         pwm_out[i] = pwm_in[i] && !(phase_current[i] > phlim[7:0]);
      end
      hot_warning_n = !s_q.hot;
      oc_warn_n = ~s_q.wpin;
      smb_alert_n = !(|s_q.sts);
   end
endmodule

/* File: test/fpm_checker_properties.sv */
/* port checker for the fault manager, bound to its top module.
 assumes warning limits of 64 C or more and hiccups of 8+ cycles. */
`timescale 1ns/10ps
module fpm_checker #(
   parameter int unsigned HIC_CYC = 20
) (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // bus
   input  wire logic              s_axi_bvalid,
   // loops
   input  fpm_pkg::fpm_loop_in_t  loop_in [2],
   input  fpm_pkg::fpm_loop_out_t loop_out [2],
   // phases
   input  wire logic [3:0]        pwm_in,
   input  wire logic [3:0]        pwm_out,
   // temperature and warnings
   input  wire logic [1:0][8:0]   temp_sense_input,
   input  wire logic              hot_warning_n,
   input  wire logic [1:0]        oc_warn_n,
   input  wire logic              smb_alert_n
);
   import fpm_pkg::*;
   logic [1:0]  en_q;
   logic        rise_q;
   logic [31:0] hic_n;
   // enable edges and hiccup length
   always_ff @(posedge aclk) begin
      en_q   <= {loop_in[1].en, loop_in[0].en};
      rise_q <= |({loop_in[1].en, loop_in[0].en} & ~en_q);
      if (!aresetn || !loop_out[0].hiccup)
         hic_n <= 32'h0;
      else
         hic_n <= hic_n + 32'h1;
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence hic_hold;
      loop_out[0].hiccup [*8];
   endsequence
   //////////////////////////////////////////////////////////////////////
   a_pwm_only_cut : assert property (
      (pwm_out & ~pwm_in) == 4'h0) else $error("pwm pulse added");
   a_hot_sets : assert property (
      (temp_sense_input[0] > 9'h0FF || temp_sense_input[1] > 9'h0FF)
      |=> !hot_warning_n)
      else $error("hot warning missed");
   a_hot_clears : assert property (
      temp_sense_input == 18'h0 |=> hot_warning_n)
      else $error("hot warning stuck");
   a_clamp_stops : assert property (
      loop_out[0].low_side_on |-> !loop_out[0].run)
      else $error("clamp while running");
   a_hiccup_stops : assert property (
      loop_out[0].hiccup |-> !loop_out[0].run)
      else $error("hiccup while running");
   a_hiccup_holds : assert property (
      $rose(loop_out[0].hiccup) |-> hic_hold) else $error("hiccup short");
   a_hiccup_length : assert property (
      $fell(loop_out[0].hiccup) |-> hic_n + 32'h1 >= HIC_CYC
      && hic_n <= HIC_CYC + 32'h1) else $error("hiccup length off");
   a_run_needs_en : assert property (
      loop_out[1].run |-> loop_in[1].en) else $error("run while off");
   a_warn_fast : assert property (
      loop_in[0].isum_a == 10'h3FF && loop_in[1].isum_a == 10'h3FF
      |-> ##[1:40] oc_warn_n != 2'b11) else $error("warn pin late");
   a_alert_kept : assert property (
      $rose(smb_alert_n) |-> $past(s_axi_bvalid) || rise_q)
      else $error("status cleared unasked");
endmodule
bind fpm_vr_fault_protection_manager fpm_checker #(.HIC_CYC(HIC_CYC))
   fpm_checker_inst (.aclk, .aresetn, .s_axi_bvalid, .loop_in, .loop_out,
   .pwm_in, .pwm_out, .temp_sense_input, .hot_warning_n, .oc_warn_n,
   .smb_alert_n);

/* File: test/fpm_stage_model.sv */
/* power stage stand-in: temperature output and rail fault.
 assumes requests change just after a rising edge. */
`timescale 1ns/10ps
module fpm_stage_model (
   // clock and reset
   input  wire logic            aclk,
   input  wire logic            aresetn,
   // requests
   input  wire logic [1:0][8:0] temp_req,
   input  wire logic [1:0]      fault_req,
   // stage outputs
   output logic [1:0][8:0]      temp_out,
   output logic [1:0]           rail_out
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         temp_out <= {9'h019, 9'h019};
         rail_out <= 2'b00;
      end else begin
         temp_out <= temp_req;
         // fault pulls output to top rail
         rail_out <= fault_req;
      end
   end
endmodule

/* File: test/tb_vr_fault_protection_manager.sv */
/* bench for the fault manager: bus tasks, stage model, scenarios.
 assumes HIC_CYC of 20 and a 10 MHz clock. */
`timescale 1ns/10ps
`include "fpm_params.svh"
module tb_vr_fault_protection_manager;
   import fpm_pkg::*;
   localparam logic [7:0] RA [4] = '{`FPM_A_RESP, `FPM_A_OT, `FPM_A_WARN,
      8'h28};
   localparam logic [31:0] RV [4] = '{`FPM_R_RESP, `FPM_R_OT, `FPM_R_WARN,
      32'h0};
   localparam logic [7:0] OCC [3] = '{8'hC0, 8'hF8, 8'hF0};
   localparam int OCN [3] = '{0, 7, 6};
   localparam logic [8:0] T0 [5] = '{9'h065, 9'h060, 9'h05E, 9'h0, 9'h0};
   localparam logic [8:0] T1 [5] = '{9'h0, 9'h0, 9'h0, 9'h12C, 9'h0};
   localparam logic HE [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
   localparam logic [15:0] VO [5] = '{16'h044C, 16'h0A28, 16'h00C8,
      16'h0A28, 16'h0384};
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, h;
   logic awready, wready, bvalid, arready, rvalid, hot_n, alert_n;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [1:0] bresp, rresp, r, rail_req, rail, oc_warn_n;
   fpm_loop_in_t lp [2];
   fpm_loop_in_t loop_in [2];
   fpm_loop_out_t loop_out [2];
   logic [3:0][7:0] pcur;
   logic [3:0] pwm_in, pwm_out;
   logic [1:0][8:0] temp_req, temp;
   int mismatches, comparisons, cyc, n;
   always_comb begin
      loop_in = lp;
      loop_in[0].stage_rail = rail[0];
      loop_in[1].stage_rail = rail[1];
   end
   fpm_vr_fault_protection_manager #(.HIC_CYC(20))
      fpm_vr_fault_protection_manager_inst (.aclk, .aresetn,
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .loop_in, .loop_out, .phase_current(pcur),
      .pwm_in, .pwm_out, .temp_sense_input(temp), .hot_warning_n(hot_n),
      .oc_warn_n, .smb_alert_n(alert_n));
   fpm_stage_model fpm_stage_model_inst (.aclk, .aresetn, .temp_req,
      .fault_req(rail_req), .temp_out(temp), .rail_out(rail));
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   //////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] rs);
      logic ah, wh, bh;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'b111;
      bh = 1'b0;
      while (!bh) begin
         @(negedge aclk);
         ah = awvalid & awready;
         wh = wvalid & wready;
         bh = bvalid;
         rs = bresp;
         @(posedge aclk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] rs);
      logic ah, rh;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      rh = 1'b0;
      while (!rh) begin
         @(negedge aclk);
         ah = arvalid & arready;
         rh = rvalid;
         d = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ah) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask
   task automatic go(input int k);
      repeat (k) @(posedge aclk);
      @(negedge aclk);
   endtask
   task automatic enc();
      @(posedge aclk);
      {lp[0].en, lp[1].en, lp[0].iout_a} <= '0;
      @(posedge aclk);
      {lp[0].en, lp[1].en} <= 2'b11;
      // let a running hiccup end before the next scenario counts
      do begin
         @(negedge aclk);
      end while (loop_out[0].hiccup);
   endtask
   task automatic finish_test();
      $display("%0d mismatches, %0d comparisons", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      cyc = 0;
      forever begin
         @(posedge aclk);
         cyc++;
         if (cyc > 20000) begin
            mismatches++;
            finish_test();
         end
      end
   end
   //////////////////////////////////////////////////////////////////////
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, pcur, pwm_in, temp_req, rail_req} = '0;
      lp[0] = '0;
      lp[1] = '0;
      v = $urandom(5);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(RA[i], v, r);
         check(v, RV[i]);
         check(32'(r), (i == 3) ? 32'h2 : 32'h0);
      end
      wr(8'h28, 32'h0, r);
      check(32'(r), 32'h2);
      $display("registers done");
      wr(`FPM_A_PHLIM, 32'h0000_0050, r);
      for (int k = 0; k < 8; k++) begin
         @(posedge aclk);
         pwm_in <= (k == 0) ? 4'hF : 4'($urandom);
         pcur <= (k == 0) ? 32'h5150_00FF : $urandom;
         go(0);
         for (int i = 0; i < 4; i++)
            check(32'(pwm_out[i]),
               32'(pwm_in[i] && pcur[i] <= 8'h50));
      end
      for (int i = 0; i < 5; i++) begin
         @(posedge aclk);
         temp_req <= {T1[i], T0[i]};
         go(3);
         check(32'(hot_n), 32'(HE[i]));
      end
      $display("pwm and hot done");
      wr(`FPM_A_OCWARN, 32'h0032_0032, r);
      for (int s = 0; s < 3; s++) begin
         wr(`FPM_A_WARN, (s << 2) | s, r);
         for (int l = 0; l < 2; l++) begin
            @(posedge aclk);
            lp[l].isum_a <= 10'h0C8;
            go(2);
            check(32'(oc_warn_n),
               (s == 2 || s == l) ? 32'h0 : 32'h3);
            @(posedge aclk);
            lp[l].isum_a <= 10'h0;
            go(3);
            check(32'(oc_warn_n), 32'h3);
         end
      end
      wr(`FPM_A_WARN, 32'h0001_000C, r);
      @(posedge aclk);
      {lp[0].isum_a, lp[1].isum_a} <= 20'hFFFFF;
      go(2);
      check(32'(oc_warn_n[0]), 32'h0);
      @(posedge aclk);
      {lp[0].isum_a, lp[1].isum_a} <= 20'h0;
      go(30);
      check(32'(oc_warn_n[0]), 32'h0);
      go(30);
      check(32'(oc_warn_n[0]), 32'h1);
      $display("warn pins done");
      wr(`FPM_A_OCLIM, 32'h0032_0032, r);
      @(posedge aclk);
      {lp[0].vout_mv, lp[1].vout_mv} <= {16'h0384, 16'h0384};
      {lp[0].en, lp[1].en, lp[0].iout_a} <= {2'b11, 10'h12C};
      go(10);
      check(32'(loop_out[0].run), 32'h1);
      @(posedge aclk);
      {lp[0].ss_done, lp[1].ss_done, lp[0].dynamic_voltage_change_up} <= 3'b111;
      go(10);
      check(32'(loop_out[0].run), 32'h1);
      for (int i = 0; i < 3; i++) begin
         enc();
         wr(`FPM_A_RESP, {8'hC0, OCC[i], 16'h8080}, r);
         @(posedge aclk);
         {lp[0].dynamic_voltage_change_up, lp[0].iout_a} <= {1'b0, 10'h12C};
         n = 0;
         h = 1'b0;
         repeat (300) begin
            @(negedge aclk);
            if (loop_out[0].hiccup && !h) n++;
            h = loop_out[0].hiccup;
         end
         check((n > 7) ? 7 : n, OCN[i]);
         if (i != 1) check(32'(loop_out[0].run), 32'h0);
      end
      enc();
      wr(`FPM_A_OT, 32'h0001_7D64, r);
      wr(`FPM_A_RESP, 32'hC0C0_8080, r);
      @(posedge aclk);
      lp[0].iout_a <= 10'h12C;
      go(45);
      check(32'(loop_out[0].run), 32'h1);
      go(10);
      check(32'(loop_out[0].run), 32'h0);
      $display("overcurrent done");
      enc();
      wr(`FPM_A_OVCFG, 32'h0000_0008, r);
      @(posedge aclk);
      lp[0].vout_mv <= 16'h0410;
      go(3);
      check(32'(loop_out[0].low_side_on), 32'h0);
      @(posedge aclk);
      {lp[0].dynamic_voltage_change_down, lp[0].vout_mv} <= {1'b1, 16'h044C};
      go(3);
      check(32'(loop_out[0].low_side_on), 32'h0);
      @(posedge aclk);
      lp[0].dynamic_voltage_change_down <= 1'b0;
      go(3);
      check(32'(loop_out[0].low_side_on), 32'h1);
      check(32'(loop_out[1].run), 32'h0);
      @(posedge aclk);
      lp[0].vout_mv <= 16'h0384;
      rd(`FPM_A_STATUS, v, r);
      check(32'(v[0]), 32'h1);
      check(32'(loop_out[0].low_side_on), 32'h1);
      wr(`FPM_A_CTRL, 32'h0000_0041, r);
      rd(`FPM_A_STATUS, v, r);
      check(32'(v[9:0]), 32'h0);
      enc();
      wr(`FPM_A_CTRL, 32'h0000_0007, r);
      for (int i = 0; i < 5; i++) begin
         @(posedge aclk);
         lp[0].vout_mv <= VO[i];
         go(3);
         check(32'(loop_out[0].low_side_on), 32'(i != 0 && i != 2));
      end
      $display("overvoltage done");
      enc();
      wr(`FPM_A_CTRL, 32'h0000_0021, r);
      @(posedge aclk);
      rail_req <= 2'b01;
      go(3);
      check(32'(loop_out[0].run), 32'h1);
      check(32'(alert_n), 32'h0);
      wr(`FPM_A_CTRL, 32'h0000_0001, r);
      go(3);
      check(32'(loop_out[0].run), 32'h0);
      $display("stage fault done");
      wr(`FPM_A_RESP, 32'h80C0_8080, r);
      @(posedge aclk);
      {rail_req, temp_req} <= {2'b00, 9'h0, 9'h12C};
      go(3);
      enc();
      @(posedge aclk);
      temp_req <= '0;
      go(3);
      check(32'(loop_out[0].run), 32'h0);
      enc();
      go(1);
      check(32'(loop_out[0].run), 32'h1);
      $display("temperature latch done");
      finish_test();
   end
endmodule
